// [src/rtcat_consts.svh]
// Register offsets, field masks, reset values and timing counts of the
// alarm, trim and scratch block. Included by the trim and core modules and the bench.
`ifndef RTCAT_CONSTS_SVH
`define RTCAT_CONSTS_SVH

`define RTCAT_ADDR_TRIM 4'h7
`define RTCAT_ADDR_WMIN 4'h8
`define RTCAT_ADDR_WHOUR 4'h9
`define RTCAT_ADDR_WDAYS 4'hA
`define RTCAT_ADDR_DMIN 4'hB
`define RTCAT_ADDR_DHOUR 4'hC
`define RTCAT_ADDR_SCRATCH 4'hD

`define RTCAT_MIN_MASK 8'h7F
`define RTCAT_HOUR_MASK 8'h3F
`define RTCAT_DAYS_MASK 8'h7F
`define RTCAT_HOUR_D5 5
`define RTCAT_TRIM_SEL_BIT 7
`define RTCAT_TRIM_DIR_BIT 6

`define RTCAT_ALARM_RST 8'h00
`define RTCAT_TRIM_RST 8'h00
`define RTCAT_SCRATCH_RST 8'h00

`define RTCAT_SEC_00 8'h00
`define RTCAT_SEC_20 8'h20
`define RTCAT_SEC_40 8'h40

`define RTCAT_SEC_COUNT 32'h0000_8000
`define RTCAT_CLK_HZ 32'h0262_5A00
`define RTCAT_OSC_HZ 32'h0000_8000
`define RTCAT_OSC_DIV (`RTCAT_CLK_HZ / `RTCAT_OSC_HZ)

`endif

// [src/rtcat_pkg.sv]
// Shared types of the alarm, trim and scratch block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package rtcat_pkg;
    typedef logic [7:0] rtcat_byte_t;
    typedef logic [15:0] rtcat_count_t;
    typedef logic [5:0] rtcat_mag_t;
endpackage
`default_nettype wire

// [src/rtcat_trim.sv]
// One-second divider with trim of the count at the adjustment seconds.
// Assumes osc_en is a one-cycle pulse at the oscillator rate and that
// sec_bcd is the live BCD seconds counter on the same clock.
`include "rtcat_consts.svh"
`default_nettype none
module rtcat_trim
    import rtcat_pkg::*;
#(
    parameter int unsigned SEC_COUNT = `RTCAT_SEC_COUNT
)(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic osc_en,
    input wire logic trim_interval_select,
    input wire logic trim_direction,
    input wire rtcat_mag_t trim_magnitude,
    input wire logic trim_wr,
    input wire rtcat_byte_t sec_bcd,
    output logic sec_tick,
    output rtcat_count_t period
);
    if (SEC_COUNT < 256 || SEC_COUNT > 65000)
    begin : g_count_check
        $error("SEC_COUNT out of range");
    end

    localparam rtcat_count_t BASE = rtcat_count_t'(SEC_COUNT);

    logic instant;
    logic apply;
    logic [7:0] add_amt;
    logic [7:0] sub_amt;
    rtcat_count_t period_d, period_q, cnt_d, cnt_q;
    logic skip_d, skip_q, tick_d, tick_q;

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        instant = (sec_bcd == `RTCAT_SEC_00) ||
            (!trim_interval_select && (sec_bcd == `RTCAT_SEC_20 ||
            sec_bcd == `RTCAT_SEC_40));
        // A write in the current second cancels this second's trim
        apply = instant && !skip_q && !trim_wr &&
            (trim_magnitude != 6'h00);
        add_amt = {1'b0, trim_magnitude - 6'h01, 1'b0};
        sub_amt = {({1'b0, ~trim_magnitude} + 7'h01), 1'b0};
        period_d = BASE;
        if (apply)
            period_d = trim_direction ? BASE - {8'h00, sub_amt}
                                      : BASE + {8'h00, add_amt};
        skip_d = trim_wr ? 1'b1 : (tick_q ? 1'b0 : skip_q);
        cnt_d = cnt_q;
        tick_d = 1'b0;
        if (osc_en)
        begin
            if (cnt_q >= period_q - 16'h0001)
            begin
                cnt_d = 16'h0000;
                tick_d = 1'b1;
            end
            else
                cnt_d = cnt_q + 16'h0001;
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            period_q <= BASE;
            cnt_q <= 16'h0000;
            skip_q <= 1'b0;
            tick_q <= 1'b0;
        end
        else
        begin
            period_q <= period_d;
            cnt_q <= cnt_d;
            skip_q <= skip_d;
            tick_q <= tick_d;
        end
    end

    assign sec_tick = tick_q;
    assign period = period_q;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    trim_add_a: assert property (!trim_direction && !trim_interval_select
        && sec_bcd == `RTCAT_SEC_40 && !skip_q && !trim_wr
        && trim_magnitude != 6'h00
        |=> period_q == BASE + 16'(2 * ($past(trim_magnitude) - 1)))
        else $error("lengthened count wrong");
    trim_unity_a: assert property (!trim_direction
        && trim_magnitude == 6'h01 |=> period_q == BASE)
        else $error("magnitude one altered count");
    trim_sub_a: assert property (trim_direction && trim_interval_select
        && sec_bcd == `RTCAT_SEC_00 && !skip_q && !trim_wr
        && trim_magnitude == 6'h3E |=> period_q == BASE - 16'h0004)
        else $error("shortened count wrong");
    trim_idle_a: assert property (!instant |=> period_q == BASE)
        else $error("trim outside adjustment second");
    trim_zero_a: assert property (trim_magnitude == 6'h00
        |=> period_q == BASE)
        else $error("zero magnitude altered count");
    trim_wrskip_a: assert property (trim_wr || skip_q
        |=> period_q == BASE && (skip_q || $past(tick_q)))
        else $error("trim applied in write second");
    trim_cov_c: cover property (apply ##1 period_q != BASE);
endmodule
`default_nettype wire

// [src/rtcat_core.sv]
// Alarm comparators, trim register, scratch byte and one-second tick.
// Assumes a protocol engine on core_clk presents reg_addr, reg_wr and
// reg_wdata and takes reg_rdata, and that the live time counters are
// BCD values on the same clock; nrst marks power-up from zero volts.
//
// Summary of operation
// - Direction 0, select 0 adds (magnitude-1)*2 clocks at 00, 20, 40 s.
// - Magnitude one with direction 0 leaves the second at 32768 clocks.
// - Select 1 trims only second 00; negative 111110 gives 32764 clocks.
// - Trim alters only the second count, never the 32.768 kHz clock enable.
// - Bit 5 of the weekly alarm hour is the PM flag or the 20-hours bit.
// - Bit 5 of the daily alarm hour is the PM flag or the 20-hours bit.
// - 12-hour midnight is hour 12 and noon hour 32, compared as stored.
// - Each day-mask bit enables one weekday code 0 to 6 for the weekly match.
// - An all-zero day mask suppresses the weekly alarm entirely.
// - The scratch byte keeps any written value and resets to zero.
// - Interval select 0 trims at seconds 00, 20, 40; select 1 only at 00.
// - Direction 1 subtracts (~magnitude+1)*2; zero magnitude does nothing.
// - An adjustment second with a trim register write is not trimmed.
`include "rtcat_consts.svh"
`default_nettype none
module rtcat_core
    import rtcat_pkg::*;
#(
    parameter int unsigned OSC_DIV = `RTCAT_OSC_DIV,
    parameter int unsigned SEC_COUNT = `RTCAT_SEC_COUNT
)(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [3:0] reg_addr,
    input wire logic reg_wr,
    input wire rtcat_byte_t reg_wdata,
    output rtcat_byte_t reg_rdata,
    input wire rtcat_byte_t cur_sec,
    input wire rtcat_byte_t cur_min,
    input wire rtcat_byte_t cur_hour,
    input wire logic [2:0] cur_wday,
    output logic clk32_en,
    output logic sec_tick,
    output logic alarm_w_hit,
    output logic alarm_d_hit
);
    if (OSC_DIV < 2 || OSC_DIV > 4096)
    begin : g_div_check
        $error("OSC_DIV out of range");
    end

    localparam logic [11:0] DIV_LAST = 12'(OSC_DIV - 1);

    ////////////////////////////////////////////////////////////////////////
    // Oscillator-rate enable, free running
    logic [11:0] div_d, div_q;
    logic en32_d, en32_q;

    always_comb
    begin
        en32_d = (div_q == DIV_LAST);
        div_d = en32_d ? 12'h000 : div_q + 12'h001;
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            div_q <= 12'h000;
            en32_q <= 1'b0;
        end
        else
        begin
            div_q <= div_d;
            en32_q <= en32_d;
        end
    end

    assign clk32_en = en32_q;

    ////////////////////////////////////////////////////////////////////////
    // Register file
    rtcat_byte_t trim_d, trim_q, wmin_d, wmin_q, whour_d, whour_q;
    rtcat_byte_t wdays_d, wdays_q, dmin_d, dmin_q, dhour_d, dhour_q;
    rtcat_byte_t scratch_d, scratch_q, rdata_d, rdata_q;
    logic trim_wr;

    always_comb
    begin
        trim_d = trim_q;
        wmin_d = wmin_q;
        whour_d = whour_q;
        wdays_d = wdays_q;
        dmin_d = dmin_q;
        dhour_d = dhour_q;
        scratch_d = scratch_q;
        trim_wr = 1'b0;
        if (reg_wr)
        begin
            unique case (reg_addr)
                `RTCAT_ADDR_TRIM:
                begin
                    trim_d = reg_wdata;
                    trim_wr = 1'b1;
                end
                `RTCAT_ADDR_WMIN: wmin_d = reg_wdata & `RTCAT_MIN_MASK;
                // Bit 5 kept verbatim: PM flag or 20-hours digit
                `RTCAT_ADDR_WHOUR:
                    whour_d = reg_wdata & `RTCAT_HOUR_MASK;
                `RTCAT_ADDR_WDAYS:
                    wdays_d = reg_wdata & `RTCAT_DAYS_MASK;
                `RTCAT_ADDR_DMIN: dmin_d = reg_wdata & `RTCAT_MIN_MASK;
                `RTCAT_ADDR_DHOUR:
                    dhour_d = reg_wdata & `RTCAT_HOUR_MASK;
                `RTCAT_ADDR_SCRATCH: scratch_d = reg_wdata;
                default: ;
            endcase
        end
        unique case (reg_addr)
            `RTCAT_ADDR_TRIM: rdata_d = trim_q;
            `RTCAT_ADDR_WMIN: rdata_d = wmin_q;
            `RTCAT_ADDR_WHOUR: rdata_d = whour_q;
            `RTCAT_ADDR_WDAYS: rdata_d = wdays_q;
            `RTCAT_ADDR_DMIN: rdata_d = dmin_q;
            `RTCAT_ADDR_DHOUR: rdata_d = dhour_q;
            `RTCAT_ADDR_SCRATCH: rdata_d = scratch_q;
            // Time and control registers live outside this block
            default: rdata_d = 8'h00;
        endcase
    end

    // Power-up reset values; the alarm bytes are undefined otherwise
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            trim_q <= `RTCAT_TRIM_RST;
            wmin_q <= `RTCAT_ALARM_RST;
            whour_q <= `RTCAT_ALARM_RST;
            wdays_q <= `RTCAT_ALARM_RST;
            dmin_q <= `RTCAT_ALARM_RST;
            dhour_q <= `RTCAT_ALARM_RST;
            scratch_q <= `RTCAT_SCRATCH_RST;
            rdata_q <= 8'h00;
        end
        else
        begin
            trim_q <= trim_d;
            wmin_q <= wmin_d;
            whour_q <= whour_d;
            wdays_q <= wdays_d;
            dmin_q <= dmin_d;
            dhour_q <= dhour_d;
            scratch_q <= scratch_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    ////////////////////////////////////////////////////////////////////////
    // Trimmed one-second count
    rtcat_count_t sec_period;

    rtcat_trim #(
        .SEC_COUNT(SEC_COUNT)
    ) u_trim (
        .core_clk(core_clk),
        .nrst(nrst),
        .osc_en(en32_q),
        .trim_interval_select(trim_q[`RTCAT_TRIM_SEL_BIT]),
        .trim_direction(trim_q[`RTCAT_TRIM_DIR_BIT]),
        .trim_magnitude(trim_q[5:0]),
        .trim_wr(trim_wr),
        .sec_bcd(cur_sec),
        .sec_tick(sec_tick),
        .period(sec_period)
    );

    ////////////////////////////////////////////////////////////////////////
    // Alarm comparators. Hours compare raw, so the 12-hour codes 12 and
    // 32 match only when the counter uses the same mode; an invalid BCD
    // setting simply never matches.
    logic w_match, d_match;
    logic wm_d, wm_q, dm_d, dm_q, wh_d, wh_q, dh_d, dh_q;

    always_comb
    begin
        // Mask bit 7 is always zero, so code 7 can never match
        w_match = (cur_min == wmin_q) && (cur_hour == whour_q) &&
            wdays_q[cur_wday];
        d_match = (cur_min == dmin_q) && (cur_hour == dhour_q);
        wm_d = w_match;
        dm_d = d_match;
        wh_d = w_match && !wm_q;
        dh_d = d_match && !dm_q;
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wm_q <= 1'b0;
            dm_q <= 1'b0;
            wh_q <= 1'b0;
            dh_q <= 1'b0;
        end
        else
        begin
            wm_q <= wm_d;
            dm_q <= dm_d;
            wh_q <= wh_d;
            dh_q <= dh_d;
        end
    end

    assign alarm_w_hit = wh_q;
    assign alarm_d_hit = dh_q;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    osc_steady_a: assert property (clk32_en |-> $past(div_q) == DIV_LAST
        && $past(div_q, 2) == DIV_LAST - 12'h001)
        else $error("oscillator enable spacing wrong");
    whour_d5_a: assert property (reg_wr && reg_addr == `RTCAT_ADDR_WHOUR
        |=> whour_q[`RTCAT_HOUR_D5] == $past(reg_wdata[`RTCAT_HOUR_D5]))
        else $error("weekly hour bit 5 lost");
    dhour_d5_a: assert property (reg_wr && reg_addr == `RTCAT_ADDR_DHOUR
        |=> dhour_q == ($past(reg_wdata) & `RTCAT_HOUR_MASK))
        else $error("daily hour bits wrong");
    noon_code_a: assert property ((dhour_q == 8'h12 || dhour_q == 8'h32)
        && cur_min == dmin_q && cur_hour == dhour_q && !dm_q
        |=> alarm_d_hit)
        else $error("midnight or noon code did not match");
    day_mask_a: assert property (alarm_w_hit |->
        $past(wdays_q[cur_wday]) && $past(cur_wday) != 3'h7)
        else $error("weekly hit on masked day");
    no_days_a: assert property (wdays_q == 8'h00 [*2]
        |-> !alarm_w_hit)
        else $error("weekly hit with empty mask");
    scratch_keep_a: assert property (reg_wr
        && reg_addr == `RTCAT_ADDR_SCRATCH ##1 !reg_wr
        && reg_addr == `RTCAT_ADDR_SCRATCH
        |=> reg_rdata == $past(reg_wdata, 2))
        else $error("scratch byte not returned");
    once_per_min_a: assert property (dm_q && d_match
        |=> !alarm_d_hit)
        else $error("daily alarm repeated");
    upper_zero_a: assert property (reg_addr == `RTCAT_ADDR_WMIN
        || reg_addr == `RTCAT_ADDR_DMIN |=> reg_rdata[7] == 1'b0)
        else $error("unused alarm bit read as one");

    weekly_hit_c: cover property (alarm_w_hit);
    daily_hit_c: cover property (alarm_d_hit);
    trim_long_c: cover property (sec_tick && sec_period != 16'(SEC_COUNT));
endmodule
`default_nettype wire

// [verification/rtcat_time_model.sv]
// Live time counter model standing beside the alarm, trim and scratch block.
// Assumes sec_tick pulses on core_clk; bench loads never meet a carry.
`default_nettype none
module rtcat_time_model
    import rtcat_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic sec_tick,
    input wire logic ld,
    input wire rtcat_byte_t ld_min,
    input wire rtcat_byte_t ld_hour,
    input wire logic [2:0] ld_wday,
    output rtcat_byte_t cur_sec,
    output rtcat_byte_t cur_min,
    output rtcat_byte_t cur_hour,
    output logic [2:0] cur_wday
);
    timeunit 1ns;
    timeprecision 1ps;

    // BCD step with wrap at 59; hours never roll, the runs are short
    function automatic rtcat_byte_t bcd_step(rtcat_byte_t v);
        if (v == 8'h59)
            return 8'h00;
        if (v[3:0] == 4'h9)
            return {v[7:4] + 4'h1, 4'h0};
        return v + 8'h01;
    endfunction

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cur_sec <= 8'h00;
            cur_min <= 8'h00;
            cur_hour <= 8'h00;
            cur_wday <= 3'h0;
        end
        else if (ld)
        begin
            cur_min <= ld_min;
            cur_hour <= ld_hour;
            cur_wday <= ld_wday;
        end
        else if (sec_tick)
        begin
            cur_sec <= bcd_step(cur_sec);
            if (cur_sec == 8'h59)
                cur_min <= bcd_step(cur_min);
        end
    end
endmodule
`default_nettype wire

// [verification/rtcat_core_bench.sv]
// Self-checking bench of the alarm, trim and scratch block.
// Assumes the time counter model stands in for the live counters.
`include "rtcat_consts.svh"
`default_nettype none
module rtcat_core_bench
    import rtcat_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned SEC = 40;
    localparam int unsigned OSC = 4;
    logic core_clk = 0, nrst = 0, reg_wr = 0, ld = 0, rd_v = 0, skip = 0;
    logic clk32_en, sec_tick, alarm_w_hit, alarm_d_hit, run = 0;
    logic [3:0] reg_addr = 4'h0;
    logic [2:0] cur_wday, ld_wday = 3'h0;
    rtcat_byte_t reg_wdata = 8'h00, ld_min = 8'h00, ld_hour = 8'h00;
    rtcat_byte_t reg_rdata, cur_sec, cur_min, cur_hour, trim_m = 8'h00;
    rtcat_byte_t rd_q[$];
    logic [15:0] rnd = 16'h8b1b;
    int failures = 0, num_checks = 0, w_hits = 0, d_hits = 0;
    int cyc = 0, ecyc = 0;

    always #12.5 core_clk = ~core_clk;

    rtcat_core #(.OSC_DIV(OSC), .SEC_COUNT(SEC)) u_dut (
        .core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .cur_sec(cur_sec), .cur_min(cur_min), .cur_hour(cur_hour),
        .cur_wday(cur_wday), .clk32_en(clk32_en), .sec_tick(sec_tick),
        .alarm_w_hit(alarm_w_hit), .alarm_d_hit(alarm_d_hit));

    rtcat_time_model u_time (
        .core_clk(core_clk), .nrst(nrst), .sec_tick(sec_tick), .ld(ld),
        .ld_min(ld_min), .ld_hour(ld_hour), .ld_wday(ld_wday),
        .cur_sec(cur_sec), .cur_min(cur_min), .cur_hour(cur_hour),
        .cur_wday(cur_wday));

    ////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH t=%0t seen %0h want %0h", $time, seen, exp);
        end
    endtask

    function automatic logic [15:0] lfsr(logic [15:0] x);
        return {1'b0, x[15:1]} ^ (x[0] ? 16'hb400 : 16'h0000);
    endfunction

    function automatic rtcat_byte_t fmask(logic [3:0] a);
        if (a == `RTCAT_ADDR_WHOUR || a == `RTCAT_ADDR_DHOUR)
            return 8'h3f;
        if (a == `RTCAT_ADDR_SCRATCH)
            return 8'hff;
        return 8'h7f;
    endfunction

    // Cycles expected for the second that just ended
    function automatic int exp_cyc(rtcat_byte_t s);
        logic adj;
        logic [5:0] inv;
        int p;
        inv = ~trim_m[5:0];
        adj = trim_m[7] ? (s == 8'h00) : (s == 8'h00 || s == 8'h20 ||
              s == 8'h40);
        p = SEC;
        if (adj && !skip && trim_m[5:0] != 6'h00)
            p = trim_m[6] ? SEC - (inv + 1) * 2 : SEC + (trim_m[5:0] - 1) * 2;
        return p * OSC;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [3:0] a, input rtcat_byte_t d);
        @(negedge core_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1;
        if (a == `RTCAT_ADDR_TRIM)
        begin
            trim_m = d;
            skip = 1;
        end
        @(negedge core_clk);
        reg_wr = 0;
    endtask

    task automatic rd(input logic [3:0] a, input rtcat_byte_t e);
        @(negedge core_clk);
        reg_addr = a;
        rd_q.push_back(e);
        rd_v = 1;
        @(negedge core_clk);
        rd_v = 0;
    endtask

    // Trim writes follow a tick so they never share its edge
    task automatic wait_tick();
        int i;
        i = 0;
        do
        begin
            @(negedge core_clk);
            i++;
        end
        while (sec_tick !== 1'b1 && i < 400);
        if (i >= 400)
        begin
            failures++;
            results();
        end
        @(negedge core_clk);
    endtask

    task automatic try_time(input rtcat_byte_t m, input rtcat_byte_t h,
                            input logic [2:0] w, input int ew, input int ed);
        int w0, d0;
        w0 = w_hits;
        d0 = d_hits;
        @(negedge core_clk);
        ld_min = m;
        ld_hour = h;
        ld_wday = w;
        ld = 1;
        @(negedge core_clk);
        ld = 0;
        repeat (8) @(negedge core_clk);
        chk(w_hits - w0, ew);
        chk(d_hits - d0, ed);
    endtask

    ////////////////////////////////////////////////////////////////////////
    always @(posedge core_clk)
    begin
        #1;
        if (rd_v)
            chk(reg_rdata, rd_q.pop_front());
    end

    always @(negedge core_clk)
    begin
        w_hits += (alarm_w_hit === 1'b1);
        d_hits += (alarm_d_hit === 1'b1);
        cyc++;
        ecyc++;
        if (clk32_en === 1'b1)
        begin
            if (run)
                chk(ecyc, OSC);
            ecyc = 0;
        end
        if (sec_tick === 1'b1)
        begin
            if (run)
                chk(cyc, exp_cyc(cur_sec));
            cyc = 0;
            run = 1;
            skip = 0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        rtcat_byte_t v;
        rtcat_byte_t trims[4];
        trims = '{8'h07, 8'h01, 8'hfe, 8'h40};
        repeat (8) @(posedge core_clk);
        @(negedge core_clk);
        nrst = 1;
        for (int a = 3; a < 15; a++)
            rd(a[3:0], 8'h00);
        chk(d_hits, 1);
        chk(w_hits, 0);
        for (int r = 0; r < 3; r++)
            for (int a = 8; a < 14; a++)
            begin
                rnd = lfsr(rnd);
                v = (r == 0) ? 8'hff : rnd[7:0];
                wr(a[3:0], v);
                rd(a[3:0], v & fmask(a[3:0]));
            end
        wr(4'he, 8'h5a);
        rd(4'he, 8'h00);
        // 12:30 p.m. and 12:59 a.m. in 12-hour form, both valid BCD
        wr(`RTCAT_ADDR_WMIN, 8'h30);
        wr(`RTCAT_ADDR_WHOUR, 8'h32);
        wr(`RTCAT_ADDR_DMIN, 8'h59);
        wr(`RTCAT_ADDR_DHOUR, 8'h12);
        try_time(8'h31, 8'h32, 3'h0, 0, 0);
        for (int d = 0; d < 7; d++)
        begin
            wr(`RTCAT_ADDR_WDAYS, 8'h01 << d);
            try_time(8'h30, 8'h32, 3'((d + 1) % 7), 0, 0);
            try_time(8'h30, 8'h32, 3'(d), 1, 0);
        end
        wr(`RTCAT_ADDR_WDAYS, 8'h00);
        try_time(8'h30, 8'h32, 3'h2, 0, 0);
        wr(`RTCAT_ADDR_WDAYS, 8'h7f);
        // Enabling the mask while the time matches fires exactly once
        try_time(8'h30, 8'h32, 3'h2, 1, 0);
        try_time(8'h30, 8'h12, 3'h1, 0, 0);
        try_time(8'h30, 8'h32, 3'h1, 1, 0);
        try_time(8'h59, 8'h32, 3'h1, 0, 0);
        try_time(8'h59, 8'h12, 3'h1, 0, 1);
        for (int t = 0; t < 4; t++)
        begin
            wait_tick();
            wr(`RTCAT_ADDR_TRIM, trims[t]);
            rd(`RTCAT_ADDR_TRIM, trims[t]);
            repeat (61) wait_tick();
        end
        wait_tick();
        wr(`RTCAT_ADDR_TRIM, 8'h07);
        for (int i = 0; i < 70 && cur_sec !== 8'h20; i++)
            wait_tick();
        chk(cur_sec, 8'h20);
        wr(`RTCAT_ADDR_TRIM, 8'h07);
        repeat (3) wait_tick();
        results();
    end
endmodule
`default_nettype wire
